// File: logic/acdb_pkg.sv
// Purpose: shared constants of the adc digital back end
// Assumes: byte addresses on a 32-bit avalon-mm register bus
// Notes:   one aligned word per register, unused bits read zero
package acdb_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ACDB_OFF_CLK   = 8'h00;
	localparam logic [7:0] ACDB_OFF_CTRL  = 8'h04;
	localparam logic [7:0] ACDB_OFF_DCM   = 8'h08;
	localparam logic [7:0] ACDB_OFF_DCR   = 8'h0c;
	localparam logic [7:0] ACDB_OFF_DCRES = 8'h10;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int ACDB_CLK_FIRST_LSB  = 0;
	localparam int ACDB_CLK_SECOND_LSB = 8;
	localparam int ACDB_CLK_OSR_LSB    = 16;
	localparam int ACDB_CTRL_POWER_BIT = 0;
	localparam int ACDB_CTRL_DMIC_BIT  = 1;
	localparam int ACDB_CTRL_GPF_LSB   = 2;
	localparam int ACDB_CTRL_WL_LSB    = 8;
	localparam int ACDB_DCM_EN_BIT     = 7;
	localparam int ACDB_DCM_IIR_BIT    = 5;
	localparam int ACDB_DCR_LATCH_BIT  = 6;
	localparam int ACDB_DCR_PER_BIT    = 5;
	// ************************************************************
	// reset values and codes
	// ************************************************************
	localparam logic [31:0] ACDB_RST_CLK  = 32'h0080_0101;
	localparam logic [31:0] ACDB_RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] ACDB_RST_DCM  = 32'h0000_0001;
	localparam logic [31:0] ACDB_RST_DCR  = 32'h0000_0000;
	localparam logic [3:0]  ACDB_GPF_MODCLK = 4'ha;
	localparam logic [4:0]  ACDB_D_MIN = 5'h01;
	localparam logic [4:0]  ACDB_D_MAX = 5'h14;
	localparam logic [23:0] ACDB_DC_PLUS_ONE  = 24'h40_0000;
	localparam logic [23:0] ACDB_DC_MINUS_ONE = 24'hc0_0000;
	typedef enum logic [0:0] {
		ACDB_ST_IDLE = 1'b0,
		ACDB_ST_ACK  = 1'b1
	} acdb_bus_t;
endpackage : acdb_pkg

// File: logic/acdb_top.sv
// Purpose: mono adc back end, serial words, digital mic, dc measure
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   decimation is a plain integrate-and-dump of the bit stream
`timescale 1ns/1ns
module acdb_top
	import acdb_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        serial_data_in,
	input  wire logic        analog_mod_bit_in,
	output logic             modulator_clock_out,
	output logic             general_purpose_pin_one_out,
	output logic             general_purpose_pin_one_oe_out,
	output logic      [31:0] left_word_out,
	output logic      [31:0] right_word_out,
	output logic             word_valid_out
);
	// ************************************************************
	// register bus
	// ************************************************************
	acdb_bus_t   state, next_state;
	logic [31:0] rdata, next_rdata;
	logic [31:0] clk_reg, next_clk_reg, ctrl_reg, next_ctrl_reg;
	logic [31:0] dcm_reg, next_dcm_reg, dcr_reg, next_dcr_reg;
	logic [23:0] readback, next_readback;
	logic [23:0] dc_result, next_dc_result;
	logic        req;

	// merge write data under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & (state == ACDB_ST_IDLE);
	assign avs_readdata_out = rdata;

	// decode, read mux and register writes
	always_comb begin
		next_state    = state;
		next_rdata    = rdata;
		next_clk_reg  = clk_reg;
		next_ctrl_reg = ctrl_reg;
		next_dcm_reg  = dcm_reg;
		next_dcr_reg  = dcr_reg;
		next_readback = readback;
		case (state)
			ACDB_ST_IDLE: begin
				if (req) begin
					next_state = ACDB_ST_ACK;
					case (avs_address_in)
						ACDB_OFF_CLK:   next_rdata = clk_reg;
						ACDB_OFF_CTRL:  next_rdata = ctrl_reg;
						ACDB_OFF_DCM:   next_rdata = dcm_reg;
						ACDB_OFF_DCR:   next_rdata = dcr_reg;
						ACDB_OFF_DCRES: next_rdata = {8'h00, readback};
						default:        next_rdata = 32'h0000_0000;
					endcase
				end
			end
			ACDB_ST_ACK: begin
				next_state = ACDB_ST_IDLE;
				if (avs_write_in) begin
					case (avs_address_in)
						ACDB_OFF_CLK: begin
							next_clk_reg = merge(clk_reg, avs_writedata_in,
								avs_byteenable_in) & 32'h00ff_7f7f;
						end
						ACDB_OFF_CTRL: begin
							next_ctrl_reg = merge(ctrl_reg, avs_writedata_in,
								avs_byteenable_in) & 32'h0000_033f;
						end
						ACDB_OFF_DCM: begin
							next_dcm_reg = merge(dcm_reg, avs_writedata_in,
								avs_byteenable_in) & 32'h0000_00bf;
						end
						ACDB_OFF_DCR: begin
							next_dcr_reg = merge(dcr_reg, avs_writedata_in,
								avs_byteenable_in) & 32'h0000_007f;
						end
						default: next_state = ACDB_ST_IDLE;
					endcase
				end
			end
			default: next_state = ACDB_ST_IDLE;
		endcase
		if (next_dcr_reg[ACDB_DCR_LATCH_BIT] && !dcr_reg[ACDB_DCR_LATCH_BIT]) begin
			next_readback = dc_result;
		end
	end

	// bus registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state    <= ACDB_ST_IDLE;
			rdata    <= 32'h0000_0000;
			clk_reg  <= ACDB_RST_CLK;
			ctrl_reg <= ACDB_RST_CTRL;
			dcm_reg  <= ACDB_RST_DCM;
			dcr_reg  <= ACDB_RST_DCR;
			readback <= 24'h00_0000;
		end else begin
			state    <= next_state;
			rdata    <= next_rdata;
			clk_reg  <= next_clk_reg;
			ctrl_reg <= next_ctrl_reg;
			dcm_reg  <= next_dcm_reg;
			dcr_reg  <= next_dcr_reg;
			readback <= next_readback;
		end
	end

	// ************************************************************
	// clock dividers and modulator clock
	// ************************************************************
	logic [6:0] f_first, f_second;
	logic [7:0] f_osr, n_first, n_second, half;
	logic [8:0] n_osr;
	logic [7:0] cnt1, next_cnt1, cnt2, next_cnt2;
	logic       mod_clk, next_mod_clk, tick1, mod_rise, power, dmic, dc_en;

	assign f_first  = clk_reg[ACDB_CLK_FIRST_LSB +: 7];
	assign f_second = clk_reg[ACDB_CLK_SECOND_LSB +: 7];
	assign f_osr    = clk_reg[ACDB_CLK_OSR_LSB +: 8];
	assign power    = ctrl_reg[ACDB_CTRL_POWER_BIT];
	assign dmic     = ctrl_reg[ACDB_CTRL_DMIC_BIT];
	assign dc_en    = dcm_reg[ACDB_DCM_EN_BIT];
	assign n_first  = (f_first == 7'h00) ? 8'h80 : {1'b0, f_first};
	assign n_second = (f_second == 7'h00) ? 8'h80 : {1'b0, f_second};
	// zero means 256, below two is raised to two
	assign n_osr    = (f_osr == 8'h00) ? 9'h100 :
		(f_osr < 8'h02) ? 9'h002 : {1'b0, f_osr};
	assign half     = 8'((9'(n_second) + 9'h001) >> 1);
	// codec clock over first then second divider
	// compare with >= so a divider shrunk while running wraps at once
	assign tick1    = (cnt1 >= n_first - 8'h01);
	assign mod_rise = power & tick1 & (cnt2 >= n_second - 8'h01);

	// divider counters
	always_comb begin
		next_cnt1 = 8'h00;
		next_cnt2 = 8'h00;
		if (power) begin
			next_cnt1 = tick1 ? 8'h00 : cnt1 + 8'h01;
			next_cnt2 = cnt2;
			if (tick1) begin
				next_cnt2 = (cnt2 >= n_second - 8'h01) ? 8'h00 : cnt2 + 8'h01;
			end
		end
		next_mod_clk = power & (next_cnt2 < half);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt1    <= 8'h00;
			cnt2    <= 8'h00;
			mod_clk <= 1'b0;
		end else begin
			cnt1    <= next_cnt1;
			cnt2    <= next_cnt2;
			mod_clk <= next_mod_clk;
		end
	end

	assign modulator_clock_out = mod_clk;
	assign general_purpose_pin_one_oe_out =
		(ctrl_reg[ACDB_CTRL_GPF_LSB +: 4] == ACDB_GPF_MODCLK);
	assign general_purpose_pin_one_out = general_purpose_pin_one_oe_out & mod_clk;

	// ************************************************************
	// audio decimation and serial words
	// ************************************************************
	logic [8:0]  osr_cnt, next_osr_cnt;
	logic [9:0]  acc, next_acc, sum10;
	logic [31:0] word, next_word, mask;
	logic        valid, next_valid, mod_bit;

	// mic mode bypasses the analog modulator
	assign mod_bit = dmic ? serial_data_in : analog_mod_bit_in;
	assign sum10   = acc + (mod_bit ? 10'h001 : 10'h3ff);

	// keep only the interface word length
	always_comb begin
		case (ctrl_reg[ACDB_CTRL_WL_LSB +: 2])
			2'b00:   mask = 32'hffff_0000;
			2'b01:   mask = 32'hffff_f000;
			2'b10:   mask = 32'hffff_ff00;
			default: mask = 32'hffff_ffff;
		endcase
	end

	// one bit per modulator clock rise
	always_comb begin
		next_osr_cnt = osr_cnt;
		next_acc     = acc;
		next_word    = word;
		next_valid   = 1'b0;
		if (!power || dc_en) begin
			next_osr_cnt = 9'h000;
			next_acc     = 10'h000;
		end else if (mod_rise) begin
			// one word pair per sample period
			if (osr_cnt == n_osr - 9'h001) begin
				next_word    = {sum10, 22'h00_0000} & mask;
				next_valid   = 1'b1;
				next_osr_cnt = 9'h000;
				next_acc     = 10'h000;
			end else begin
				next_osr_cnt = osr_cnt + 9'h001;
				next_acc     = sum10;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			osr_cnt <= 9'h000;
			acc     <= 10'h000;
			word    <= 32'h0000_0000;
			valid   <= 1'b0;
		end else begin
			osr_cnt <= next_osr_cnt;
			acc     <= next_acc;
			word    <= next_word;
			valid   <= next_valid;
		end
	end

	assign left_word_out  = word;
	assign right_word_out = word;
	assign word_valid_out = valid;

	// ************************************************************
	// dc measurement
	// ************************************************************
	logic [4:0]  d_raw, d_eff;
	logic [20:0] avg_len, avg_cnt, next_avg_cnt;
	logic [21:0] dc_sum, next_dc_sum, sum22;
	logic [31:0] per_cnt, next_per_cnt, per_lim;
	logic [23:0] iir_y, next_iir_y, x_in;
	logic [24:0] diff;
	logic [43:0] scaled;
	logic        per_hit, iir_mode;

	assign d_raw    = dcm_reg[4:0];
	assign d_eff    = (d_raw < ACDB_D_MIN) ? ACDB_D_MIN :
		(d_raw > ACDB_D_MAX) ? ACDB_D_MAX : d_raw;
	assign iir_mode = dcm_reg[ACDB_DCM_IIR_BIT];
	assign avg_len  = 21'h00_0001 << d_eff;
	assign per_lim  = (32'h0000_0001 << dcr_reg[4:0]) - 32'h0000_0001;
	assign per_hit  = dcr_reg[ACDB_DCR_PER_BIT] & (per_cnt == per_lim);
	assign sum22    = dc_sum + (mod_bit ? 22'h00_0001 : 22'h3f_ffff);
	assign scaled   = 44'($signed({sum22, 22'h00_0000}) >>> d_eff);
	assign x_in     = mod_bit ? ACDB_DC_PLUS_ONE : ACDB_DC_MINUS_ONE;
	assign diff     = {x_in[23], x_in} - {iir_y[23], iir_y};

	// filters run only in dc mode
	always_comb begin
		next_avg_cnt   = avg_cnt;
		next_dc_sum    = dc_sum;
		next_per_cnt   = per_cnt;
		next_iir_y     = iir_y;
		next_dc_result = dc_result;
		if (!power || !dc_en) begin
			next_avg_cnt = 21'h00_0000;
			next_dc_sum  = 22'h00_0000;
			next_per_cnt = 32'h0000_0000;
		end else if (mod_rise) begin
			next_per_cnt = (per_hit || !dcr_reg[ACDB_DCR_PER_BIT]) ?
				32'h0000_0000 : per_cnt + 32'h0000_0001;
			if (iir_mode) begin
				next_iir_y     = iir_y + 24'($signed(diff) >>> d_eff);
				next_dc_result = next_iir_y;
			end else if (per_hit) begin
				next_avg_cnt = 21'h00_0000;
				next_dc_sum  = 22'h00_0000;
			end else if (avg_cnt == avg_len - 21'h00_0001) begin
				next_dc_result = scaled[23:0];
				next_avg_cnt   = 21'h00_0000;
				next_dc_sum    = 22'h00_0000;
			end else begin
				next_avg_cnt = avg_cnt + 21'h00_0001;
				next_dc_sum  = sum22;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			avg_cnt   <= 21'h00_0000;
			dc_sum    <= 22'h00_0000;
			per_cnt   <= 32'h0000_0000;
			iir_y     <= 24'h00_0000;
			dc_result <= 24'h00_0000;
		end else begin
			avg_cnt   <= next_avg_cnt;
			dc_sum    <= next_dc_sum;
			per_cnt   <= next_per_cnt;
			iir_y     <= next_iir_y;
			dc_result <= next_dc_result;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	word_pulse_a: assert property (valid |=> !valid)
		else $error("word valid longer than one cycle");
	lr_equal_a: assert property (valid |-> left_word_out == right_word_out)
		else $error("left and right words differ");
	word_round_a: assert property ((valid && ctrl_reg[9:8] == 2'b00) |-> word[15:0] == 16'h0000)
		else $error("word not rounded to 16 bits");
	pin_func_a: assert property (general_purpose_pin_one_oe_out |-> general_purpose_pin_one_out == modulator_clock_out)
		else $error("pin does not carry modulator clock");
	mic_bit_a: assert property ((mod_rise && dmic && !dc_en && osr_cnt != n_osr - 9'h001)
		|=> acc == $past(acc) + ($past(serial_data_in) ? 10'h001 : 10'h3ff))
		else $error("mic bit not taken at clock rise");
	dc_quiet_a: assert property ((dc_en && $past(dc_en)) |-> !valid)
		else $error("audio word in dc mode");
	iir_track_a: assert property ((power && dc_en && iir_mode && mod_rise) |=> dc_result == iir_y)
		else $error("iir result not updated");
	per_clear_a: assert property ((power && dc_en && !iir_mode && mod_rise && per_hit) |=> dc_sum == 22'h00_0000 ##0 avg_cnt == 21'h00_0000)
		else $error("periodic reset missed");
	rb_copy_a: assert property ($rose(dcr_reg[ACDB_DCR_LATCH_BIT]) |-> readback == $past(dc_result))
		else $error("latch did not copy result");
	rb_hold_a: assert property ((dcr_reg[ACDB_DCR_LATCH_BIT] && $past(dcr_reg[ACDB_DCR_LATCH_BIT])) |-> $stable(readback))
		else $error("read-back moved while latched");
	div_range_a: assert property (cnt1 < n_first && cnt2 < n_second)
		else $error("divider count out of range");
endmodule : acdb_top

// File: tb/acdb_mic_model.sv
// Purpose: one-bit digital microphone on the far side of the data pin
// Assumes: modulator clock comes from the block under test
// Notes:   data changes after each clock fall; toggles when clock idles
`timescale 1ns/1ns
module acdb_mic_model (
	input  wire logic clk_in,
	input  wire logic modulator_clock_in,
	input  wire logic level_in,
	output logic      data_out
);
	logic       prev_clk;
	logic [4:0] idle;
	initial begin
		prev_clk = 1'b0;
		idle = 5'h0;
		data_out = 1'b0;
	end
	// ************************************************************
	// data pin driver
	// ************************************************************
	// mic drives from our clock
	always @(negedge clk_in) begin
		prev_clk <= modulator_clock_in;
		idle <= modulator_clock_in ? 5'h0 : ((idle == 5'h1f) ? idle : idle + 5'h1);
		if (prev_clk && !modulator_clock_in)
			data_out <= level_in;
		else if (idle > 5'h10)
			data_out <= ~data_out; // no stale bit while idle
	end
endmodule : acdb_mic_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the adc back end
// Assumes: bus answer time taken from waitrequest, one clock domain
// Notes:   audio rows in a table, dc measurement tested by hand
`timescale 1ns/1ns
module testbench;
	import acdb_pkg::*;
	typedef struct packed {
		logic [1:0]  wl;
		logic        lvl;
		logic [31:0] exp;
	} acdb_row_t;
	localparam int LIMIT = 20000;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h0;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hf;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        serial_data_in;
	logic        modulator_clock_out;
	logic        gp_pin;
	logic        gp_oe;
	logic [31:0] left_word_out;
	logic [31:0] right_word_out;
	logic        word_valid_out;
	logic        mic_level = 1'b0;
	logic [31:0] q;
	logic [31:0] n;
	logic        p0;
	acdb_row_t   rows [4];
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	acdb_top dut (
		.clk_in                         (clk_in),
		.rst_n_in                       (rst_n_in),
		.avs_address_in                 (avs_address_in),
		.avs_read_in                    (avs_read_in),
		.avs_write_in                   (avs_write_in),
		.avs_writedata_in               (avs_writedata_in),
		.avs_byteenable_in              (avs_byteenable_in),
		.avs_readdata_out               (avs_readdata_out),
		.avs_waitrequest_out            (avs_waitrequest_out),
		.serial_data_in                 (serial_data_in),
		.analog_mod_bit_in              (1'b0),
		.modulator_clock_out            (modulator_clock_out),
		.general_purpose_pin_one_out    (gp_pin),
		.general_purpose_pin_one_oe_out (gp_oe),
		.left_word_out                  (left_word_out),
		.right_word_out                 (right_word_out),
		.word_valid_out                 (word_valid_out)
	);
	acdb_mic_model mic (
		.clk_in             (clk_in),
		.modulator_clock_in (modulator_clock_out),
		.level_in           (mic_level),
		.data_out           (serial_data_in)
	);

	// ************************************************************
	// clock, timeout, helpers
	// ************************************************************
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles = cycles + 1;
		if (cycles == LIMIT) begin
			n_errors = n_errors + 1;
			print_verdict();
		end
	end
	task print_verdict();
		$display("errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// one avalon access, held until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in   <= a;
		avs_writedata_in <= d;
		avs_write_in     <= wr;
		avs_read_in      <= ~wr;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
	endtask : bus
	task wait_valid();
		n = 32'h0;
		do begin
			@(negedge clk_in);
			n = n + 32'h1;
		end while (word_valid_out !== 1'b1 && n < 32'd200);
	endtask : wait_valid

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rows[0] = '{2'h0, 1'h1, 32'h0100_0000};
		rows[1] = '{2'h1, 1'h0, 32'hff00_0000};
		rows[2] = '{2'h2, 1'h1, 32'h0100_0000};
		rows[3] = '{2'h3, 1'h0, 32'hff00_0000};
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		check({28'h0, modulator_clock_out, gp_oe, word_valid_out, gp_pin}, 32'h0);
		check(left_word_out, 32'h0);
		bus(1'b0, ACDB_OFF_CLK, 32'h0);
		check(q, ACDB_RST_CLK);
		bus(1'b0, ACDB_OFF_DCM, 32'h0);
		check(q, ACDB_RST_DCM);
		bus(1'b0, ACDB_OFF_DCR, 32'h0);
		check(q, ACDB_RST_DCR);
		bus(1'b1, 8'h20, 32'hffff_ffff);
		bus(1'b0, 8'h20, 32'h0);
		check(q, 32'h0);
		// first 1, second 10, ratio 4: 5 MHz modulator, word every 40 clocks
		// ratio times rate is 5 MHz
		// no processing block here, first divider left at 1
		bus(1'b1, ACDB_OFF_CLK, 32'h0004_0a01);
		foreach (rows[i]) begin
			mic_level <= rows[i].lvl;
			bus(1'b1, ACDB_OFF_CTRL, {22'h0, rows[i].wl, 8'h2b});
			wait_valid();
			wait_valid();
			wait_valid();
			check(n, 32'd40);
			check(left_word_out, rows[i].exp);
			check(right_word_out, left_word_out);
			p0 = gp_pin;
			repeat (5) @(negedge clk_in);
			check({30'h0, gp_oe, gp_pin}, {30'h0, 1'b1, ~p0});
		end
		bus(1'b1, ACDB_OFF_CTRL, 32'h0000_0003);
		@(negedge clk_in);
		check({30'h0, gp_oe, gp_pin}, 32'h0);
		// dc mode A, D=1, all ones: no audio words
		mic_level <= 1'b1;
		bus(1'b1, ACDB_OFF_DCM, 32'h0000_0081);
		n = 32'h0;
		repeat (100) begin
			@(negedge clk_in);
			n = n + {31'h0, word_valid_out};
		end
		check(n, 32'h0);
		bus(1'b1, ACDB_OFF_DCR, 32'h0000_0040);
		bus(1'b0, ACDB_OFF_DCRES, 32'h0);
		check(q, {8'h0, ACDB_DC_PLUS_ONE});
		mic_level <= 1'b0;
		repeat (100) @(posedge clk_in);
		bus(1'b0, ACDB_OFF_DCRES, 32'h0);
		check(q, {8'h0, ACDB_DC_PLUS_ONE});
		// mode A with periodic reset every 4 ticks still yields results
		mic_level <= 1'b1;
		bus(1'b1, ACDB_OFF_DCR, 32'h0000_0022);
		repeat (100) @(posedge clk_in);
		bus(1'b1, ACDB_OFF_DCR, 32'h0000_0062);
		bus(1'b0, ACDB_OFF_DCRES, 32'h0);
		check(q, {8'h0, ACDB_DC_PLUS_ONE});
		// mode B converges down to -1.0, then fresh latch
		mic_level <= 1'b0;
		bus(1'b1, ACDB_OFF_DCM, 32'h0000_00a1);
		repeat (400) @(posedge clk_in);
		bus(1'b1, ACDB_OFF_DCR, 32'h0);
		bus(1'b1, ACDB_OFF_DCR, 32'h0000_0040);
		bus(1'b0, ACDB_OFF_DCRES, 32'h0);
		check(q, {8'h0, ACDB_DC_MINUS_ONE});
		bus(1'b1, ACDB_OFF_DCR, 32'h0);
		bus(1'b0, ACDB_OFF_DCR, 32'h0);
		check(q, ACDB_RST_DCR);
		print_verdict();
	end
endmodule : testbench
